// file: logic/mbdec_bus_end.sv
// Far bus end: issues CSR commands to the node, observes and completes its requests
`timescale 1ns/1ps
module mbdec_bus_end (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_we,
  input wire logic sw_re,
  output logic [31:0] sw_rdata,
  mbdec_bus_if.bus bus
);
  // All state of the bus end in one record
  typedef struct packed {
    logic [22:0] cmd_addr; // CSR address to send
    logic [31:0] cmd_data; // Write data to send
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic [31:0] rd_data; // Last reply from the node
    logic [34:0] last_addr; // Last command seen from the node
    logic [2:0] last_code;
    logic [5:0] last_bank;
    logic [31:0] last_data;
    logic done;
    logic [5:0] done_bank;
    logic [31:0] reply_data; // Data answered to node CSR reads
    logic rvalid;
    logic [31:0] rdata;
    logic [31:0] sw_rdata;
  } mbdec_end_s;

  mbdec_end_s s; // Registered state
  mbdec_end_s next_s; // Next state

  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.done = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.sw_rdata = 32'h0000_0000;
    // Software writes
    if (sw_we)
    begin
      case (sw_addr)
        mbdec_pkg::SW_CMD_ADDR: next_s.cmd_addr = sw_wdata[22:0];
        mbdec_pkg::SW_CMD_DATA: next_s.cmd_data = sw_wdata;
        mbdec_pkg::SW_CMD_GO:
        begin
          // Bit 0 picks write over read; padding bits stay zero
          next_s.cmd_valid = 1'b1;
          next_s.cmd_code = sw_wdata[0] ? mbdec_pkg::CMD_CSR_WR : mbdec_pkg::CMD_CSR_RD;
        end
        mbdec_pkg::SW_DONE:
        begin
          next_s.done = 1'b1;
          next_s.done_bank = sw_wdata[5:0];
        end
        mbdec_pkg::SW_REPLY: next_s.reply_data = sw_wdata;
        default:
        begin
          next_s.done = 1'b0;
        end
      endcase
    end
    // Software reads, answered in the next cycle
    if (sw_re)
    begin
      case (sw_addr)
        mbdec_pkg::SW_CMD_ADDR: next_s.sw_rdata = {9'h000, s.cmd_addr};
        mbdec_pkg::SW_CMD_DATA: next_s.sw_rdata = s.cmd_data;
        mbdec_pkg::SW_RD_DATA: next_s.sw_rdata = s.rd_data;
        mbdec_pkg::SW_LAST_ADDR: next_s.sw_rdata = s.last_addr[31:0];
        mbdec_pkg::SW_LAST_INFO: next_s.sw_rdata = {13'h0000, s.last_addr[34:32], 5'h00, s.last_code, 2'h0, s.last_bank};
        mbdec_pkg::SW_REPLY: next_s.sw_rdata = s.reply_data;
        mbdec_pkg::SW_LAST_DATA: next_s.sw_rdata = s.last_data;
        default: next_s.sw_rdata = 32'h0000_0000;
      endcase
    end
    // Node reply to our CSR read
    if (bus.n_rvalid)
    begin
      next_s.rd_data = bus.n_rdata;
    end
    // Record node commands; answer its CSR reads one cycle later
    if (bus.n_cmd_valid)
    begin
      next_s.last_addr = bus.n_cmd_addr;
      next_s.last_code = bus.n_cmd_code;
      next_s.last_bank = bus.n_cmd_bank;
      next_s.last_data = bus.n_cmd_wdata;
      if (bus.n_cmd_code == mbdec_pkg::CMD_CSR_RD)
      begin
        next_s.rvalid = 1'b1;
        next_s.rdata = s.reply_data;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // Outputs from state
  assign sw_rdata = s.sw_rdata;
  assign bus.b_cmd_valid = s.cmd_valid;
  assign bus.b_cmd_code = s.cmd_code;
  assign bus.b_cmd_addr = mbdec_pkg::csr_cmd_addr(s.cmd_addr);
  assign bus.b_cmd_wdata = s.cmd_data;
  assign bus.b_done = s.done;
  assign bus.b_done_bank = s.done_bank;
  assign bus.b_rvalid = s.rvalid;
  assign bus.b_rdata = s.rdata;
endmodule

// file: logic/mbdec_bus_if.sv
// Shared system bus between a decoding node and the rest of the bus
`timescale 1ns/1ps
interface mbdec_bus_if;
  logic n_cmd_valid; // Node issues a command cycle
  logic [2:0] n_cmd_code; // Command code from node
  logic [34:0] n_cmd_addr; // Command cycle D<34:0> from node
  logic [5:0] n_cmd_bank; // Target bank of node command
  logic [31:0] n_cmd_wdata; // Write data from node
  logic b_rvalid; // Read reply to node CSR read
  logic [31:0] b_rdata; // Reply data to node
  logic b_cmd_valid; // Bus side issues a command to node
  logic [2:0] b_cmd_code; // Command code from bus side
  logic [34:0] b_cmd_addr; // Command cycle D<34:0> from bus side
  logic [31:0] b_cmd_wdata; // Write data from bus side
  logic n_rvalid; // Node replies to a CSR read
  logic [31:0] n_rdata; // Node reply data
  logic b_done; // A memory request has completed
  logic [5:0] b_done_bank; // Bank that completed
  modport node (
    output n_cmd_valid, n_cmd_code, n_cmd_addr, n_cmd_bank, n_cmd_wdata, n_rvalid, n_rdata,
    input b_rvalid, b_rdata, b_cmd_valid, b_cmd_code, b_cmd_addr, b_cmd_wdata, b_done, b_done_bank
  );
  modport bus (
    input n_cmd_valid, n_cmd_code, n_cmd_addr, n_cmd_bank, n_cmd_wdata, n_rvalid, n_rdata,
    output b_rvalid, b_rdata, b_cmd_valid, b_cmd_code, b_cmd_addr, b_cmd_wdata, b_done, b_done_bank
  );
endinterface

// file: logic/mbdec_node.sv
// Decoding bus node: slot mapping registers, bank decode and CSR windows
// Function
// - Eight mapping registers, one per slot
// - Reset clears every enable bit
// - Block address is command data 34:0
// - Select needs enable, module and interleave match
// - Derive module, interleave and bank masks
// - Bank index: shifted low bits, bank-masked
// - Bank number ORs all selecting slots
// - Software keeps selections mutually exclusive
// - Upper bank bits are slot node ID
// - Forty-bit memory, 23-bit CSR addressing
// - Sixty-four byte blocks, bit 0 wraps
// - Node CSR windows and broadcast decode
// - Bus CSRs are 32-bit, block aligned
// - CSR cycles pad bits 33:23, 0 zero
// - Local CSR space served locally only
// - No bus-visible register in local space
// - Broadcast writes taken in one transaction
// - CSR and private commands use bank 0
// - Wait while target bank is outstanding
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module mbdec_node (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] node_id,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [39:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic resp_err,
  output logic [5:0] bank,
  output logic bank_valid,
  output logic bcast_valid,
  output logic [31:0] bcast_data,
  mbdec_bus_if.node bus
);
  // All state of the node in one record
  typedef struct packed {
    mbdec_pkg::mbdec_state_e state;
    logic [7:0][31:0] map; // Slot mapping registers
    logic [63:0] busy; // Banks with a request outstanding
    logic [31:0] scratch; // Bus-visible register in own window
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic [34:0] cmd_addr;
    logic [5:0] cmd_bank;
    logic [31:0] cmd_wdata;
    logic rvalid;
    logic [31:0] rdata;
    logic resp_valid;
    logic [31:0] resp_data;
    logic resp_err;
    logic [5:0] bank;
    logic bank_valid;
    logic bcast_valid;
    logic [31:0] bcast_data;
  } mbdec_node_s;

  mbdec_node_s s; // Registered state
  mbdec_node_s next_s; // Next state
  logic [34:0] blk_addr; // Block address of the user request
  logic [7:0] sel; // Per-slot select
  logic [7:0][5:0] slot_bank; // Per-slot gated bank number
  logic [5:0] dec_bank; // Combined bank number
  logic dec_valid; // Some slot selects the address
  logic is_mem; // User request targets memory
  logic is_local; // User CSR request lies in local space
  logic [22:0] own_base; // Base of this node's CSR window
  logic [22:0] in_csr; // Incoming CSR address D<22:0>
  logic in_own; // Incoming command hits own window
  logic in_bcast; // Incoming command hits broadcast space
  logic in_csr_cmd; // Incoming command is a well-formed CSR cycle

  // Byte address 39:5 becomes command data 34:0; bit 0 picks the first half
  assign blk_addr = req_addr[mbdec_pkg::BYTE_BLK_LO +: mbdec_pkg::BLK_W];

  // One decoder per slot, each tied to its own register
  for (genvar n = 0; n < mbdec_pkg::NUM_SLOTS; n++)
  begin : g_slot
    mbdec_slot_match #(
      .SLOT(3'(n))
    ) u_match (
      .map_reg(s.map[n]),
      .blk_addr(blk_addr),
      .sel(sel[n]),
      .bank(slot_bank[n])
    );
  end

  // OR of all slot contributions; overlapping programming gives garbage by design
  always_comb
  begin
    dec_bank = 6'h00;
    for (int n = 0; n < mbdec_pkg::NUM_SLOTS; n++)
    begin
      dec_bank = dec_bank | slot_bank[n];
    end
    dec_valid = |sel;
  end

  // Request classification and own window base
  always_comb
  begin
    is_mem = (req_kind == mbdec_pkg::REQ_MEM_RD) || (req_kind == mbdec_pkg::REQ_MEM_WR);
    is_local = req_addr[22:0] < mbdec_pkg::CSR_LOCAL_LIMIT;
    // Slots 0..7 step through the node range; the I/O port has its own base
    if (node_id < mbdec_pkg::IOP_NODE_ID)
    begin
      own_base = mbdec_pkg::NODE_CSR_BASE + 23'(node_id[2:0]) * mbdec_pkg::NODE_CSR_STEP;
    end
    else
    begin
      own_base = mbdec_pkg::IOP_CSR_BASE;
    end
    in_csr = bus.b_cmd_addr[22:0];
    in_csr_cmd = bus.b_cmd_valid && mbdec_pkg::csr_fmt_ok(bus.b_cmd_addr)
                 && ((bus.b_cmd_code == mbdec_pkg::CMD_CSR_RD) || (bus.b_cmd_code == mbdec_pkg::CMD_CSR_WR));
    in_own = ((in_csr & mbdec_pkg::CSR_WINDOW_MASK) == own_base);
    in_bcast = ((in_csr & mbdec_pkg::BCAST_MASK) == mbdec_pkg::BCAST_BASE);
  end

  // Ready only when idle and, for memory, the target bank is free
  assign req_ready = ce && (s.state == mbdec_pkg::ST_IDLE)
                     && !(is_mem && dec_valid && s.busy[dec_bank]);

  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.resp_valid = 1'b0;
    next_s.bcast_valid = 1'b0;
    // Completion frees the bank; a new request set below wins over it
    if (bus.b_done)
    begin
      next_s.busy[bus.b_done_bank] = 1'b0;
    end
    // Bus commands to this node's window or to broadcast space
    if (in_csr_cmd)
    begin
      if (in_own)
      begin
        // Only offset 0 holds a register; others write nowhere and read zero
        if (bus.b_cmd_code == mbdec_pkg::CMD_CSR_WR)
        begin
          if (in_csr[16:1] == 16'h0000)
          begin
            next_s.scratch = bus.b_cmd_wdata;
          end
        end
        else
        begin
          next_s.rvalid = 1'b1;
          next_s.rdata = (in_csr[16:1] == 16'h0000) ? s.scratch : 32'h0000_0000;
        end
      end
      else if (in_bcast && (bus.b_cmd_code == mbdec_pkg::CMD_CSR_WR))
      begin
        // Write-only: bcast_valid pulses in the cycle after the command, reads are ignored
        next_s.bcast_valid = 1'b1;
        next_s.bcast_data = bus.b_cmd_wdata;
      end
    end
    // User request sequencing
    case (s.state)
      mbdec_pkg::ST_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          next_s.resp_err = 1'b0;
          next_s.resp_data = 32'h0000_0000;
          if (is_mem)
          begin
            next_s.bank = dec_bank;
            next_s.bank_valid = dec_valid;
            next_s.resp_valid = 1'b1;
            if (dec_valid)
            begin
              next_s.cmd_valid = 1'b1;
              next_s.cmd_code = (req_kind == mbdec_pkg::REQ_MEM_WR) ? mbdec_pkg::CMD_MEM_WR : mbdec_pkg::CMD_MEM_RD;
              next_s.cmd_addr = blk_addr;
              next_s.cmd_bank = dec_bank;
              next_s.cmd_wdata = req_wdata;
              next_s.busy[dec_bank] = 1'b1;
            end
            else
            begin
              // No memory answers this address, so nothing goes on the bus
              next_s.resp_err = 1'b1;
            end
          end
          else if (is_local)
          begin
            // Local space never reaches the bus; mapping registers live here
            next_s.resp_valid = 1'b1;
            if (req_addr[22:4] == 19'h00000)
            begin
              if (req_kind == mbdec_pkg::REQ_CSR_WR)
              begin
                next_s.map[req_addr[3:1]] = req_wdata;
              end
              else
              begin
                next_s.resp_data = s.map[req_addr[3:1]];
              end
            end
          end
          else
          begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_code = (req_kind == mbdec_pkg::REQ_CSR_WR) ? mbdec_pkg::CMD_CSR_WR : mbdec_pkg::CMD_CSR_RD;
            next_s.cmd_addr = mbdec_pkg::csr_cmd_addr(req_addr[22:0]);
            next_s.cmd_bank = 6'h00;
            next_s.cmd_wdata = req_wdata;
            if (req_kind == mbdec_pkg::REQ_CSR_WR)
            begin
              next_s.resp_valid = 1'b1;
            end
            else
            begin
              next_s.state = mbdec_pkg::ST_WAIT_RD;
            end
          end
        end
      end
      mbdec_pkg::ST_WAIT_RD:
      begin
        // Hold off new requests until the reply arrives
        if (bus.b_rvalid)
        begin
          next_s.resp_valid = 1'b1;
          next_s.resp_data = bus.b_rdata;
          next_s.state = mbdec_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_s.state = mbdec_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; mapping registers clear so no slot decodes after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign resp_valid = s.resp_valid;
  assign resp_data = s.resp_data;
  assign resp_err = s.resp_err;
  assign bank = s.bank;
  assign bank_valid = s.bank_valid;
  assign bcast_valid = s.bcast_valid;
  assign bcast_data = s.bcast_data;
  assign bus.n_cmd_valid = s.cmd_valid;
  assign bus.n_cmd_code = s.cmd_code;
  assign bus.n_cmd_addr = s.cmd_addr;
  assign bus.n_cmd_bank = s.cmd_bank;
  assign bus.n_cmd_wdata = s.cmd_wdata;
  assign bus.n_rvalid = s.rvalid;
  assign bus.n_rdata = s.rdata;
endmodule

// file: logic/mbdec_pkg.sv
// Shared constants, command codes and states of the memory bank decoder
package mbdec_pkg;
  localparam int NUM_SLOTS = 8;
  localparam int BLK_W = 35;
  localparam int BYTE_ADDR_W = 40;
  localparam int CSR_ADDR_W = 23;
  localparam int BANK_W = 6;
  localparam int DATA_W = 32;
  // Slot mapping register fields
  localparam int MAP_EN_BIT = 0;
  localparam int MAP_INT_LO = 1;
  localparam int MAP_IPOS_LO = 3;
  localparam int MAP_AW_LO = 5;
  localparam int MAP_NB_LO = 9;
  localparam int MAP_MADDR_LO = 17;
  localparam logic [31:0] MAP_RESET = 32'h0000_0000;
  // Block address field positions
  localparam int BLK_MOD_LO = 19;
  localparam int BLK_IPOS_LO = 1;
  localparam int BLK_BANK_LO = 1;
  localparam int BYTE_BLK_LO = 5;
  // CSR address map, in command-cycle D<22:0> units
  localparam logic [22:0] CSR_LOCAL_LIMIT = 23'h40_0000;
  localparam logic [22:0] NODE_CSR_BASE = 23'h40_0000;
  localparam logic [22:0] NODE_CSR_STEP = 23'h02_0000;
  localparam logic [22:0] IOP_CSR_BASE = 23'h50_0000;
  localparam logic [22:0] CSR_WINDOW_MASK = 23'h7e_0000;
  localparam logic [22:0] BCAST_BASE = 23'h70_0000;
  localparam logic [22:0] BCAST_MASK = 23'h70_0000;
  localparam logic [3:0] IOP_NODE_ID = 4'h8;
  // Command codes on the bus
  localparam logic [2:0] CMD_MEM_RD = 3'h0;
  localparam logic [2:0] CMD_MEM_WR = 3'h1;
  localparam logic [2:0] CMD_CSR_RD = 3'h2;
  localparam logic [2:0] CMD_CSR_WR = 3'h3;
  localparam logic [2:0] CMD_PRIV = 3'h4;
  // Node user request kinds
  localparam logic [1:0] REQ_MEM_RD = 2'h0;
  localparam logic [1:0] REQ_MEM_WR = 2'h1;
  localparam logic [1:0] REQ_CSR_RD = 2'h2;
  localparam logic [1:0] REQ_CSR_WR = 2'h3;
  // Bus end software register offsets
  localparam logic [7:0] SW_CMD_ADDR = 8'h00;
  localparam logic [7:0] SW_CMD_DATA = 8'h04;
  localparam logic [7:0] SW_CMD_GO = 8'h08;
  localparam logic [7:0] SW_RD_DATA = 8'h0c;
  localparam logic [7:0] SW_LAST_ADDR = 8'h10;
  localparam logic [7:0] SW_LAST_INFO = 8'h14;
  localparam logic [7:0] SW_DONE = 8'h18;
  localparam logic [7:0] SW_REPLY = 8'h1c;
  localparam logic [7:0] SW_LAST_DATA = 8'h20;
  // Node sequencer states, Gray along idle to wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_RD = 2'b01
  } mbdec_state_e;
  // Build a CSR command-cycle address with zero padding
  function automatic logic [34:0] csr_cmd_addr(input logic [22:0] a);
    csr_cmd_addr = {12'h000, a[22:1], 1'b0};
  endfunction
  // A CSR command address is legal only with zero padding bits
  function automatic logic csr_fmt_ok(input logic [34:0] d);
    csr_fmt_ok = (d[33:23] == 11'h000) && !d[0];
  endfunction
endpackage

// file: logic/mbdec_slot_match.sv
// One slot's mapping decode: select flag and slot bank number
`timescale 1ns/1ps
module mbdec_slot_match #(
  parameter logic [2:0] SLOT = 3'h0
) (
  input wire logic [31:0] map_reg,
  input wire logic [34:0] blk_addr,
  output logic sel,
  output logic [5:0] bank
);
  logic [14:0] mod_addr; // Module address field
  logic [1:0] ipos; // Interleave position field
  logic [1:0] iwidth; // Interleave width field
  logic [3:0] aw; // Address mask width field
  logic [1:0] bank_count; // Bank count field
  logic [14:0] mod_mask; // Top aw bits set
  logic [1:0] int_mask; // Low iwidth ones
  logic [2:0] bank_mask; // Low bank_count ones
  logic [4:0] shifted; // Low address bits after interleave shift
  logic [2:0] bank_in_module; // Bank within module

  // Field split and mask derivation
  always_comb
  begin
    mod_addr = map_reg[mbdec_pkg::MAP_MADDR_LO +: 15];
    ipos = map_reg[mbdec_pkg::MAP_IPOS_LO +: 2];
    iwidth = map_reg[mbdec_pkg::MAP_INT_LO +: 2];
    aw = map_reg[mbdec_pkg::MAP_AW_LO +: 4];
    bank_count = map_reg[mbdec_pkg::MAP_NB_LO +: 2];
    mod_mask = ~(15'h7fff >> aw);
    int_mask = ~(2'h3 << iwidth);
    bank_mask = ~(3'h7 << bank_count);
    // Enable, module address and interleave position must all match
    sel = map_reg[mbdec_pkg::MAP_EN_BIT]
          && ((blk_addr[mbdec_pkg::BLK_MOD_LO +: 15] & mod_mask) == mod_addr)
          && ((blk_addr[mbdec_pkg::BLK_IPOS_LO +: 2] & int_mask) == ipos);
    shifted = blk_addr[mbdec_pkg::BLK_BANK_LO +: 5] >> iwidth;
    bank_in_module = shifted[2:0] & bank_mask;
    // Unselected slots contribute zero to the OR
    bank = sel ? {SLOT, bank_in_module} : 6'h00;
  end
endmodule

// file: tb/mbdec_properties.sv
// Interface checker for the decoding node and the bus end
`timescale 1ns/1ps
module mbdec_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic n_cmd_valid,
  input wire logic [2:0] n_cmd_code,
  input wire logic [34:0] n_cmd_addr,
  input wire logic [5:0] n_cmd_bank,
  input wire logic b_rvalid,
  input wire logic b_cmd_valid,
  input wire logic [2:0] b_cmd_code,
  input wire logic n_rvalid,
  input wire logic b_done,
  input wire logic [5:0] b_done_bank
);
  logic [63:0] busy; // Banks with a memory command still open
  logic [63:0] next_busy;
  logic csr_cmd; // Node puts a CSR command on the bus
  logic mem_cmd; // Node puts a memory command on the bus
  assign csr_cmd = n_cmd_valid && n_cmd_code inside {mbdec_pkg::CMD_CSR_RD, mbdec_pkg::CMD_CSR_WR};
  assign mem_cmd = n_cmd_valid && n_cmd_code <= mbdec_pkg::CMD_MEM_WR;
  // Completion clears first so a new command on the same edge wins
  always_comb
  begin
    next_busy = busy;
    if (b_done)
      next_busy[b_done_bank] = 1'h0;
    if (mem_cmd)
      next_busy[n_cmd_bank] = 1'h1;
  end
  // Bitmap register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy <= 64'h0;
    else
      busy <= next_busy;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_csr_bank_zero: assert property (csr_cmd |-> n_cmd_bank == 6'h00)
    else $error("CSR command with nonzero bank");
  chk_csr_pad_zero: assert property (csr_cmd |-> n_cmd_addr[33:23] == 11'h000 && !n_cmd_addr[0])
    else $error("CSR command padding not zero");
  chk_local_stays: assert property (csr_cmd |-> n_cmd_addr[22:0] >= mbdec_pkg::CSR_LOCAL_LIMIT)
    else $error("Local CSR reference reached the bus");
  chk_bank_free: assert property (mem_cmd |-> !busy[n_cmd_bank])
    else $error("Memory command to a bank still open");
  chk_reply_follows: assert property (csr_cmd && !n_cmd_code[0] |=> b_rvalid)
    else $error("CSR read not answered next cycle");
  chk_reply_cause: assert property (b_rvalid |-> $past(csr_cmd && !n_cmd_code[0]))
    else $error("Reply without a CSR read");
  chk_node_answer: assert property (n_rvalid |-> $past(b_cmd_valid && b_cmd_code == mbdec_pkg::CMD_CSR_RD))
    else $error("Node reply without an incoming read");
  chk_read_waits: assert property (csr_cmd && !n_cmd_code[0] |=> !n_cmd_valid [*2])
    else $error("Node issued a command while awaiting a reply");
endmodule

// file: tb/memory_bank_decoder_tb.sv
// Testbench: decoding node facing the bus end through the shared interface
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module memory_bank_decoder_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic req_valid = 1'h0;
  logic [1:0] req_kind = 2'h0;
  logic [39:0] req_addr = 40'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [7:0] sw_addr = 8'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_we = 1'h0;
  logic sw_re = 1'h0;
  logic [3:0] node_id = 4'h2;
  logic req_ready, resp_valid, resp_err, bank_valid, bcast_valid;
  logic [31:0] resp_data, bcast_data, sw_rdata, rd;
  logic [5:0] bank;
  int bad_count = 0;
  int samples_checked = 0;
  mbdec_bus_if bus_if();
  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;
  // Node sits in slot 2 until the I/O port case
  mbdec_node mbdec_node_inst (.clk(clk), .rst_n(rst_n), .ce(1'h1), .node_id(node_id), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err), .bank(bank),
    .bank_valid(bank_valid), .bcast_valid(bcast_valid), .bcast_data(bcast_data), .bus(bus_if));
  mbdec_bus_end mbdec_bus_end_inst (.clk(clk), .rst_n(rst_n), .ce(1'h1), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .bus(bus_if));
  mbdec_properties mbdec_properties_inst (.clk(clk), .rst_n(rst_n), .n_cmd_valid(bus_if.n_cmd_valid),
    .n_cmd_code(bus_if.n_cmd_code), .n_cmd_addr(bus_if.n_cmd_addr), .n_cmd_bank(bus_if.n_cmd_bank),
    .b_rvalid(bus_if.b_rvalid), .b_cmd_valid(bus_if.b_cmd_valid), .b_cmd_code(bus_if.b_cmd_code),
    .n_rvalid(bus_if.n_rvalid), .b_done(bus_if.b_done), .b_done_bank(bus_if.b_done_bank));
  // Mapping word: module address, bank count, mask width, interleave position and width, enable
  function automatic logic [31:0] map_val(int nb, int ip, int iw, logic [14:0] ma, logic [3:0] aw);
    return {ma, 6'h00, 2'(nb), aw, 2'(ip), 2'(iw), 1'h1};
  endfunction
  // Node request held until taken, then the response pulse is awaited
  task automatic node_req(input logic [1:0] k, input logic [39:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'h1;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge clk); while (req_ready !== 1'h1 && ++n < 40);
    req_valid <= 1'h0;
    do @(posedge clk); while (resp_valid !== 1'h1 && ++n < 40);
    `CHK("resp_valid", 1'h1, resp_valid)
  endtask
  // Software port write, one strobe cycle
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_we <= 1'h1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_we <= 1'h0;
  endtask
  // Software port read; data only stands in the cycle after the strobe
  task automatic sw_rd(input logic [7:0] a);
    @(posedge clk);
    sw_re <= 1'h1;
    sw_addr <= a;
    @(posedge clk);
    sw_re <= 1'h0;
    @(posedge clk);
    rd = sw_rdata;
  endtask
  // Mapping registers come up disabled, so memory finds no slot
  task automatic t_reset();
    for (int n = 0; n < 8; n++)
    begin
      node_req(mbdec_pkg::REQ_CSR_RD, 40'(n) << 1, 32'h0);
      `CHK("map_reset", 32'h0, resp_data)
    end
    node_req(mbdec_pkg::REQ_MEM_RD, 40'h0, 32'h0);
    `CHK("no_slot_err", 1'h1, resp_err)
    `CHK("no_slot_valid", 1'h0, bank_valid)
  endtask
  // Interleave and bank-count mixes on slots 4..7, one slot enabled at a time
  task automatic t_map();
    logic [34:0] blk [4] = '{35'h2a, 35'h3c, 35'h16, 35'h1f};
    int iw [4] = '{0, 1, 2, 0};
    int nb [4] = '{3, 2, 3, 0};
    logic [2:0] s;
    logic [5:0] e;
    logic [31:0] m;
    for (int k = 0; k < 4; k++)
    begin
      s = 3'(k + 4);
      e = {s, 3'((blk[k][5:1] >> iw[k]) & ((1 << nb[k]) - 1))};
      m = map_val(nb[k], 32'(blk[k][2:1]) & ((1 << iw[k]) - 1), iw[k], 15'h0, 4'h0);
      node_req(mbdec_pkg::REQ_CSR_WR, 40'(s) << 1, m);
      node_req(mbdec_pkg::REQ_CSR_RD, 40'(s) << 1, 32'h0);
      `CHK("map_rw", m, resp_data)
      node_req(mbdec_pkg::REQ_MEM_RD, {blk[k], 5'h00}, 32'h0);
      `CHK("bank", e, bank)
      `CHK("bank_valid", 1'h1, bank_valid)
      sw_rd(mbdec_pkg::SW_LAST_INFO);
      `CHK("cmd_bank", e, rd[5:0])
      sw_rd(mbdec_pkg::SW_LAST_ADDR);
      `CHK("cmd_addr", blk[k][31:0], rd)
      sw_wr(mbdec_pkg::SW_DONE, 32'(e));
      node_req(mbdec_pkg::REQ_MEM_RD, {blk[k] ^ 35'h2, 5'h00}, 32'h0);
      `CHK("ipos_miss", iw[k] != 0, resp_err)
      node_req(mbdec_pkg::REQ_CSR_WR, 40'(s) << 1, 32'h0);
    end
  endtask
  // Module mask on bit 33, then a second request to an open bank is held back
  task automatic t_busy();
    node_req(mbdec_pkg::REQ_CSR_WR, 40'h2, map_val(0, 0, 0, 15'h4000, 4'h1));
    node_req(mbdec_pkg::REQ_MEM_RD, {35'h40, 5'h00}, 32'h0);
    `CHK("mask_miss", 1'h1, resp_err)
    node_req(mbdec_pkg::REQ_MEM_RD, {35'h2_0000_0000, 5'h00}, 32'h0);
    `CHK("mask_hit", 6'h08, bank)
    fork
      node_req(mbdec_pkg::REQ_MEM_WR, {35'h2_0000_0040, 5'h00}, 32'h0);
      begin
        repeat (4) @(posedge clk);
        `CHK("busy_hold", 1'h0, req_ready)
        sw_wr(mbdec_pkg::SW_DONE, 32'h8);
      end
    join
    `CHK("busy_bank", 6'h08, bank)
    sw_wr(mbdec_pkg::SW_DONE, 32'h8);
    node_req(mbdec_pkg::REQ_CSR_WR, 40'h2, 32'h0);
  endtask
  // Remote CSR read and write go out with bank 0; local space stays home
  task automatic t_remote();
    sw_wr(mbdec_pkg::SW_REPLY, 32'h5a5a_1234);
    node_req(mbdec_pkg::REQ_CSR_RD, 40'h46_0000, 32'h0);
    `CHK("remote_rd", 32'h5a5a_1234, resp_data)
    sw_rd(mbdec_pkg::SW_LAST_INFO);
    `CHK("csr_code_bank", 9'h080, {rd[10:8], rd[5:0]})
    node_req(mbdec_pkg::REQ_CSR_WR, 40'h4e_0040, 32'hc3);
    node_req(mbdec_pkg::REQ_CSR_WR, 40'h10_0000, 32'h1);
    sw_rd(mbdec_pkg::SW_LAST_DATA);
    `CHK("csr_wdata", 32'hc3, rd)
    sw_rd(mbdec_pkg::SW_LAST_ADDR);
    `CHK("csr_addr", 32'h4e_0040, rd)
  endtask
  // Incoming: own window, foreign window, I/O port window, broadcast
  task automatic t_incoming();
    int n;
    sw_wr(mbdec_pkg::SW_CMD_ADDR, 32'h44_0000);
    sw_wr(mbdec_pkg::SW_CMD_DATA, 32'h1357);
    sw_wr(mbdec_pkg::SW_CMD_GO, 32'h1);
    sw_wr(mbdec_pkg::SW_CMD_ADDR, 32'h48_0000);
    sw_wr(mbdec_pkg::SW_CMD_DATA, 32'hdead);
    sw_wr(mbdec_pkg::SW_CMD_GO, 32'h1);
    node_id <= 4'h8;
    sw_wr(mbdec_pkg::SW_CMD_ADDR, 32'h50_0000);
    sw_wr(mbdec_pkg::SW_CMD_GO, 32'h0);
    repeat (4) @(posedge clk);
    sw_rd(mbdec_pkg::SW_RD_DATA);
    `CHK("scratch", 32'h1357, rd)
    sw_wr(mbdec_pkg::SW_CMD_ADDR, 32'h70_0040);
    sw_wr(mbdec_pkg::SW_CMD_DATA, 32'h77);
    sw_wr(mbdec_pkg::SW_CMD_GO, 32'h1);
    n = 0;
    do @(posedge clk); while (bcast_valid !== 1'h1 && ++n < 8);
    `CHK("bcast_valid", 1'h1, bcast_valid)
    `CHK("bcast_data", 32'h77, bcast_data)
  endtask
  // Counts, verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_map();
    t_busy();
    t_remote();
    t_incoming();
    conclude();
  end
  // Watchdog: the tests need a few thousand cycles at most
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
